// ==== arps_consts.vh ====
// Purpose: Shared constants for the result port mode select block
// Assumes: Included by bare name from design files
// Notes: Definitions only
`ifndef ARPS_CONSTS_VH
`define ARPS_CONSTS_VH
`define ARPS_RES_W 16
`define ARPS_BYTE_W 8
`define ARPS_FIFO_DEPTH 16
`define ARPS_FIFO_AW 4
`define ARPS_HI_LO 15
`define ARPS_BIT14 14
`define ARPS_BIT15 15
`define ARPS_MODE_WORD 2'h0
`define ARPS_MODE_BYTE 2'h1
`define ARPS_MODE_SER 2'h2
`define ARPS_SYNC_N 6
`define ARPS_SYNC_RST 6'h03
`endif

// ==== arps_fifo.v ====
// Purpose: Result FIFO with valid/ready on both sides
// Assumes: Single clock, asynchronous active-high reset
// Notes: Full and empty are exact; storage is a register array
`timescale 1ns/10ps
module arps_fifo #(
    parameter WIDTH = 16,
    parameter DEPTH = 16,
    parameter AW = 4
) (
    input wire clk,
    input wire reset,
    input wire [WIDTH-1:0] in_data,
    input wire in_valid,
    output wire in_ready,
    output wire [WIDTH-1:0] out_data,
    output wire out_valid,
    input wire out_ready
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_ptr_r;
    reg [AW-1:0] rd_ptr_r;
    reg [AW:0] count_r;
    reg [AW:0] count_nxt;
    reg in_ready_r;
    wire push;
    wire pop;

    // ----------------------------------------------------------------
    // Handshake
    // ----------------------------------------------------------------
    assign in_ready = in_ready_r; // Flop, so the port output is clean
    assign out_valid = (count_r != {(AW+1){1'b0}});
    assign out_data = mem[rd_ptr_r];
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    // Next occupancy, shared by the count and the registered ready
    always @* begin
        count_nxt = count_r;
        if (push & ~pop) begin
            count_nxt = count_r + 1'b1;
        end else if (pop & ~push) begin
            count_nxt = count_r - 1'b1;
        end
    end

    // Storage has no reset; only pointers, count and ready need a defined value
    always @(posedge clk) begin
        if (push) begin
            mem[wr_ptr_r] <= in_data;
        end
    end

    // Pointers and occupancy
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            wr_ptr_r <= {AW{1'b0}};
            rd_ptr_r <= {AW{1'b0}};
            count_r <= {(AW+1){1'b0}};
            in_ready_r <= 1'b1;
        end else begin
            if (push) begin
                wr_ptr_r <= (wr_ptr_r == DEPTH[AW-1:0] - 1'b1) ?
                    {AW{1'b0}} : wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_r <= (rd_ptr_r == DEPTH[AW-1:0] - 1'b1) ?
                    {AW{1'b0}} : rd_ptr_r + 1'b1;
            end
            count_r <= count_nxt;
            in_ready_r <= (count_nxt != DEPTH[AW:0]);
        end
    end
endmodule // arps_fifo

// ==== arps_port.v ====
// Purpose: Result port mode select and parallel word/byte read sequencer
// Assumes: Host pins are asynchronous and pass two flip-flops first
// Notes: Serial shifting itself lives elsewhere; this block only
//        flags serial mode and keeps the data lines quiet then
//        Latency: pins pass two sync stages, the word is fetched on
//        the next edge and the lines are driven one edge later, so a
//        host strobe must last well over four clocks
//        Limitation: an empty buffer repeats the last word and raises
//        the underrun flag rather than stalling the host
`timescale 1ns/10ps
`include "arps_consts.vh"
module arps_port #(
    parameter RES_W = `ARPS_RES_W,
    parameter DEPTH = `ARPS_FIFO_DEPTH,
    parameter AW = `ARPS_FIFO_AW
) (
    input wire clk,
    input wire reset,
    input wire [RES_W-1:0] result_data,
    input wire result_valid,
    output wire result_ready,
    input wire chip_select_n,
    input wire read_n,
    input wire interface_select,
    input wire byte_mode_in,
    input wire high_byte_first,
    input wire reference_select,
    output reg [RES_W-1:0] data_out_r,
    output reg [RES_W-1:0] data_oe_r,
    output reg internal_ref_en_r,
    output reg serial_mode_r,
    output reg byte_mode_r,
    output reg read_underrun_r
);
    // Raw host pins in one vector so every pin gets the same two-stage
    // synchroniser; the first stage is read only by the second
    localparam [`ARPS_SYNC_N-1:0] SYNC_RST = `ARPS_SYNC_RST;
    wire [`ARPS_SYNC_N-1:0] pin_raw;
    wire [`ARPS_SYNC_N-1:0] pin_sync;
    wire cs_n_sync;
    wire rd_n_sync;
    wire is_sync;
    wire bm_sync;
    wire hb_sync;
    wire rs_sync;
    // Sequencer state
    reg access_d_r;
    reg second_byte_r;
    reg [RES_W-1:0] held_r;
    reg held_valid_r;
    reg [1:0] mode_r;
    reg [1:0] mode_nxt;
    // Decode and buffer nets
    wire access;
    wire access_rise;
    wire access_fall;
    wire parallel;
    wire [RES_W-1:0] fifo_data;
    wire fifo_valid;
    wire fifo_pop;
    wire [`ARPS_BYTE_W-1:0] byte_sel;
    wire hi_now;

    // ----------------------------------------------------------------
    // Result buffer
    // ----------------------------------------------------------------
    // Sixteen words decouple the converter from the host read pace;
    // the converter side stalls on a full buffer rather than dropping
    arps_fifo #(
        .WIDTH(RES_W),
        .DEPTH(DEPTH),
        .AW(AW)
    ) u_fifo (
        .clk(clk),
        .reset(reset),
        .in_data(result_data),
        .in_valid(result_valid),
        .in_ready(result_ready),
        .out_data(fifo_data),
        .out_valid(fifo_valid),
        .out_ready(fifo_pop)
    );

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    // Host pins are asynchronous to clk. Strobes leave reset idle high
    // and levels idle low, so no false access follows reset
    assign pin_raw = {reference_select, high_byte_first, byte_mode_in,
        interface_select, read_n, chip_select_n};
    assign {rs_sync, hb_sync, bm_sync, is_sync, rd_n_sync, cs_n_sync} =
        pin_sync;

    // All pins share the same two stages, so a mode pin and a strobe
    // that change together are seen in the same cycle
    genvar g;
    generate
        for (g = 0; g < `ARPS_SYNC_N; g = g + 1) begin : g_sync
            reg s1_r;
            reg s2_r;
            // One pin, two flip-flops
            always @(posedge clk or posedge reset) begin
                if (reset) begin
                    s1_r <= SYNC_RST[g];
                    s2_r <= SYNC_RST[g];
                end else begin
                    s1_r <= pin_raw[g];
                    s2_r <= s1_r;
                end
            end
            assign pin_sync[g] = s2_r;
        end
    endgenerate

    // ----------------------------------------------------------------
    // Mode decode
    // ----------------------------------------------------------------
    // Byte-mode input only matters with interface select high
    always @* begin
        if (!is_sync) begin
            mode_nxt = `ARPS_MODE_WORD;
        end else if (bm_sync) begin
            mode_nxt = `ARPS_MODE_BYTE;
        end else begin
            mode_nxt = `ARPS_MODE_SER;
        end
    end

    // Access is gated on the registered mode, which is reloaded every cycle,
    // so a mode pin that moves mid-strobe can split one read across two decodes
    assign parallel = (mode_r != `ARPS_MODE_SER);
    assign access = parallel & ~cs_n_sync & ~rd_n_sync;
    assign access_rise = access & ~access_d_r;
    assign access_fall = ~access & access_d_r;
    // Order input is ignored outside byte mode, so a floating host
    // pin in serial mode cannot disturb anything
    assign hi_now = hb_sync ^ second_byte_r;
    assign byte_sel = hi_now ? held_r[`ARPS_HI_LO:`ARPS_BYTE_W] :
        held_r[`ARPS_BYTE_W-1:0];

    // A new result is fetched at the start of a word read, or of the
    // first byte read; the second byte reuses the held word
    assign fifo_pop = access_rise & ~second_byte_r & fifo_valid;

    // ----------------------------------------------------------------
    // Read sequencer
    // ----------------------------------------------------------------
    // Byte position advances when a read strobe ends, so the host
    // sees stable data for the whole strobe
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            mode_r <= `ARPS_MODE_WORD;
            access_d_r <= 1'b0;
            second_byte_r <= 1'b0;
            held_r <= {RES_W{1'b0}};
            held_valid_r <= 1'b0;
            read_underrun_r <= 1'b0;
        end else begin
            mode_r <= mode_nxt;
            access_d_r <= access;
            // Leaving byte mode always restarts at the first byte
            if (mode_r != `ARPS_MODE_BYTE) begin
                second_byte_r <= 1'b0;
            end else if (access_fall) begin
                second_byte_r <= ~second_byte_r;
            end
            // Hold register keeps the word for both byte reads
            if (fifo_pop) begin
                held_r <= fifo_data;
                held_valid_r <= 1'b1;
            end
            // Empty buffer: old word repeats, flag shows the slip
            if (access_rise & ~second_byte_r) begin
                read_underrun_r <= ~fifo_valid;
            end
        end
    end

    // ----------------------------------------------------------------
    // Pin drivers
    // ----------------------------------------------------------------
    // One cycle after the fetch so the held word is already loaded
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            data_out_r <= {RES_W{1'b0}};
            data_oe_r <= {RES_W{1'b0}};
            internal_ref_en_r <= 1'b0;
            serial_mode_r <= 1'b0;
            byte_mode_r <= 1'b0;
        end else begin
            // Status outputs are registered so every pin comes from a flop
            internal_ref_en_r <= rs_sync;
            serial_mode_r <= (mode_r == `ARPS_MODE_SER);
            byte_mode_r <= (mode_r == `ARPS_MODE_BYTE);
            if (access & access_d_r & held_valid_r) begin
                if (mode_r == `ARPS_MODE_WORD) begin
                    data_out_r <= held_r;
                    data_oe_r <= {RES_W{1'b1}};
                end else begin
                    data_out_r <= {{(RES_W-`ARPS_BYTE_W){1'b0}},
                        byte_sel};
                    data_oe_r <= {{(RES_W-`ARPS_BYTE_W){1'b0}},
                        {`ARPS_BYTE_W{1'b1}}};
                end
            end else begin
                // Outside an access every line is released
                data_out_r <= {RES_W{1'b0}};
                data_oe_r <= {RES_W{1'b0}};
            end
        end
    end
endmodule // arps_port

// ==== arps_port_checker.sv ====
// Purpose: Port-level checker for arps_port
// Assumes: One clock, asynchronous active-high reset
// Notes: Latencies follow the two-stage pin sync plus one stage (reference) or two stages (mode, data)
`timescale 1ns/10ps
module arps_port_checker (
    input wire clk,
    input wire reset,
    input wire [15:0] result_data,
    input wire result_valid,
    input wire result_ready,
    input wire chip_select_n,
    input wire read_n,
    input wire interface_select,
    input wire byte_mode_in,
    input wire high_byte_first,
    input wire reference_select,
    input wire [15:0] data_out_r,
    input wire [15:0] data_oe_r,
    input wire internal_ref_en_r,
    input wire serial_mode_r,
    input wire byte_mode_r,
    input wire read_underrun_r
);
    // ----------------------------------------
    // Pin and mode relations
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    // Host access as seen on the pins
    wire acc = !chip_select_n && !read_n;
    AST_OE_PINS: assert property (data_oe_r != 16'h0000 |->
        $past(acc, 3) || $past(acc, 4)) else $error("bus driven off access");
    AST_WORD_ALL: assert property (data_oe_r != 16'h0000 &&
        !byte_mode_r && !serial_mode_r |-> data_oe_r == 16'hffff)
        else $error("word mode lines not all driven");
    AST_SER_QUIET: assert property (serial_mode_r &&
        $past(serial_mode_r) |-> data_oe_r == 16'h0000)
        else $error("lines driven in serial mode");
    AST_SER_DEC: assert property ((interface_select &&
        !byte_mode_in)[*5] |=> serial_mode_r && !byte_mode_r)
        else $error("serial mode not decoded");
    AST_BYTE_DEC: assert property ((interface_select &&
        byte_mode_in)[*5] |=> byte_mode_r && !serial_mode_r)
        else $error("byte mode not decoded");
    AST_BYTE_LANES: assert property (byte_mode_r &&
        $past(byte_mode_r) |-> data_oe_r[15:8] == 8'h00)
        else $error("upper lines driven in byte mode");
    AST_REF_ON: assert property (reference_select[*4]
        |=> internal_ref_en_r) else $error("internal reference off");
    AST_REF_OFF: assert property ((!reference_select)[*4]
        |=> !internal_ref_en_r) else $error("internal reference on");
endmodule // arps_port_checker

// ==== arps_host.sv ====
// Purpose: Host model that reads results over the strobe pins
// Assumes: Pins change on the falling clock edge
// Notes: Undriven lines show the inverse of the last value read
`timescale 1ns/10ps
module arps_host (
    input wire clk,
    input wire [15:0] data_out_r,
    input wire [15:0] data_oe_r,
    output reg chip_select_n,
    output reg read_n
);
    // ----------------------------------------
    // Wire model and read cycle
    // ----------------------------------------
    reg [15:0] last_r;
    // Released lines never echo old data, so stale reads are caught
    wire [15:0] pins = (data_out_r & data_oe_r) | (~last_r & ~data_oe_r);
    initial begin
        chip_select_n = 1'b1;
        read_n = 1'b1;
        last_r = 16'h0000;
    end
    // Both strobes low together; strobe high at least 5 cycles between reads
    task rd(output [15:0] d, output [15:0] oe);
        begin
            @(negedge clk);
            chip_select_n = 1'b0;
            read_n = 1'b0;
            repeat (6) @(negedge clk);
            oe = data_oe_r;
            d = pins;
            last_r = pins;
            chip_select_n = 1'b1;
            read_n = 1'b1;
            repeat (4) @(negedge clk);
        end
    endtask
endmodule // arps_host

// ==== arps_port_tb.sv ====
// Purpose: Self-checking bench for arps_port
// Assumes: Inputs change on the falling edge
// Notes: Mode inputs change only while the bus is idle
`timescale 1ns/10ps
module arps_port_tb;
    reg clk, reset, result_valid, interface_select, byte_mode_in;
    reg high_byte_first, reference_select;
    reg [15:0] result_data, d, oe;
    wire result_ready, chip_select_n, read_n, internal_ref_en_r;
    wire serial_mode_r, byte_mode_r, read_underrun_r;
    wire [15:0] data_out_r, data_oe_r;
    integer errors, comparisons, i;
    arps_port arps_port_i (.clk(clk), .reset(reset),
        .result_data(result_data), .result_valid(result_valid),
        .result_ready(result_ready), .chip_select_n(chip_select_n),
        .read_n(read_n), .interface_select(interface_select),
        .byte_mode_in(byte_mode_in), .high_byte_first(high_byte_first),
        .reference_select(reference_select), .data_out_r(data_out_r),
        .data_oe_r(data_oe_r), .internal_ref_en_r(internal_ref_en_r),
        .serial_mode_r(serial_mode_r), .byte_mode_r(byte_mode_r),
        .read_underrun_r(read_underrun_r));
    arps_host arps_host_i (.clk(clk), .data_out_r(data_out_r),
        .data_oe_r(data_oe_r), .chip_select_n(chip_select_n),
        .read_n(read_n));
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task check(input [63:0] name, input [15:0] seen, input [15:0] exp);
        begin
            comparisons = comparisons + 1;
            if (seen !== exp) begin
                errors = errors + 1;
                $display("[ERR] %0s exp %h seen %h", name, exp, seen);
            end
        end
    endtask
    task tally_and_finish;
        begin
            if (errors == 0 && comparisons > 0) $display("Simulation passed");
            else $display("Simulation failed");
            $finish;
        end
    endtask
    // Bounded wait for room, then one word offered for one edge
    task push(input [15:0] w);
        integer n;
        begin
            n = 0;
            while (result_ready !== 1'b1 && n < 50) begin
                @(negedge clk);
                n = n + 1;
            end
            if (result_ready !== 1'b1) begin
                errors = errors + 1;
                tally_and_finish;
            end else begin
                result_data = w;
                result_valid = 1'b1;
                @(negedge clk);
                result_valid = 1'b0;
                @(negedge clk);
            end
        end
    endtask
    task mode(input a, input b, input c);
        begin
            interface_select = a;
            byte_mode_in = b;
            high_byte_first = c;
            repeat (6) @(negedge clk);
        end
    endtask
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        {reset, reference_select} = 2'h3;
        {result_valid, interface_select, byte_mode_in} = 3'h0;
        {high_byte_first, result_data, errors, comparisons} = 0;
        repeat (2) @(posedge clk);
        @(negedge clk);
        reset = 1'b0;
        repeat (5) @(negedge clk);
        check("ref_on", {15'h0, internal_ref_en_r}, 16'h0001);
        check("ready", {15'h0, result_ready}, 16'h0001);
        for (i = 0; i < 16; i = i + 1) push({i[3:0], 12'h5a3});
        check("full", {15'h0, result_ready}, 16'h0000);
        for (i = 0; i < 16; i = i + 1) begin
            arps_host_i.rd(d, oe);
            check("word", d, {i[3:0], 12'h5a3});
            check("word_oe", oe, 16'hffff);
        end
        arps_host_i.rd(d, oe);
        check("repeat", d, 16'hf5a3);
        check("underrun", {15'h0, read_underrun_r}, 16'h0001);
        mode(1'b1, 1'b1, 1'b1);
        check("bmode", {14'h0, serial_mode_r, byte_mode_r}, 16'h0001);
        push(16'hbeef);
        arps_host_i.rd(d, oe);
        check("hi_1st", d & oe, 16'h00be);
        check("byte_oe", oe, 16'h00ff);
        check("no_undr", {15'h0, read_underrun_r}, 16'h0000);
        arps_host_i.rd(d, oe);
        check("lo_2nd", d & oe, 16'h00ef);
        mode(1'b1, 1'b1, 1'b0);
        push(16'hcafe);
        arps_host_i.rd(d, oe);
        check("lo_1st", d & oe, 16'h00fe);
        arps_host_i.rd(d, oe);
        check("hi_2nd", d & oe, 16'h00ca);
        mode(1'b1, 1'b0, 1'b0);
        check("smode", {14'h0, serial_mode_r, byte_mode_r}, 16'h0002);
        push(16'h1357);
        arps_host_i.rd(d, oe);
        check("ser_oe", oe, 16'h0000);
        reference_select = 1'b0;
        repeat (6) @(negedge clk);
        check("ref_off", {15'h0, internal_ref_en_r}, 16'h0000);
        tally_and_finish;
    end
endmodule // arps_port_tb
bind arps_port arps_port_checker arps_port_checker_i (.clk(clk),
    .reset(reset), .result_data(result_data), .result_valid(result_valid),
    .result_ready(result_ready), .chip_select_n(chip_select_n),
    .read_n(read_n), .interface_select(interface_select),
    .byte_mode_in(byte_mode_in), .high_byte_first(high_byte_first),
    .reference_select(reference_select), .data_out_r(data_out_r),
    .data_oe_r(data_oe_r), .internal_ref_en_r(internal_ref_en_r),
    .serial_mode_r(serial_mode_r), .byte_mode_r(byte_mode_r),
    .read_underrun_r(read_underrun_r));
